// ### include/lfc_consts.vh
// constants for the led flash mode and fault controller
`ifndef LFC_CONSTS_VH
`define LFC_CONSTS_VH

// ********************************************
// register word indices (address bits 5:2)
// ********************************************
`define LFC_IDX_INPUT_VOLTAGE_FLASH_MONITOR      4'h1
`define LFC_IDX_RAMP      4'h6
`define LFC_IDX_FEAT      4'h8
`define LFC_IDX_CURR      4'h9
`define LFC_IDX_ENABLE    4'hA
`define LFC_IDX_FLAGS     4'hB
`define LFC_IDX_FAULTIN   4'hC
`define LFC_IDX_STATUS    4'hD
`define LFC_AW            6

// ********************************************
// reset values
// ********************************************
`define LFC_RST_ENABLE    8'h00
`define LFC_RST_FEAT      8'h52
`define LFC_RST_CURR      8'h0F
`define LFC_RST_INPUT_VOLTAGE_FLASH_MONITOR      8'h80

// ********************************************
// field positions
// ********************************************
`define LFC_MODE_LO       0
`define LFC_MODE_HI       1
`define LFC_EN_TORCHPIN   4
`define LFC_EN_STROBE     5
`define LFC_EN_TX         6
`define LFC_EN_INPUT_VOLTAGE_FLASH_MONITOR       7
`define LFC_FEAT_TO_LO    0
`define LFC_FEAT_TO_HI    2
`define LFC_CURR_FL_LO    0
`define LFC_CURR_FL_HI    3
`define LFC_CURR_TO_LO    4
`define LFC_CURR_TO_HI    6
`define LFC_INPUT_VOLTAGE_FLASH_MONITOR_LOW_INPUT_LOCK_ENABLE  7
`define LFC_FL_TIMEOUT    0
`define LFC_FL_TSD        1
`define LFC_FL_SHORT      2
`define LFC_FL_OVP        3
`define LFC_FL_UNDERVOLTAGE_LOCKOUT       4
`define LFC_FL_INPUT_VOLTAGE_FLASH_MONITOR       5

// ********************************************
// modes
// ********************************************
`define LFC_MODE_STBY     2'h0
`define LFC_MODE_IND      2'h1
`define LFC_MODE_TORCH    2'h2
`define LFC_MODE_FLASH    2'h3

// ********************************************
// timing
// ********************************************
`define LFC_CLK_MHZ       100
`define LFC_TO_STEP_MS    100
`define LFC_LED_DG_US     256
`define LFC_OUT_DG_US     2048
`define LFC_STEP_US       1

`endif

// ### hw/lfc_sync.v
// two flip-flop synchroniser bank
`timescale 1ns/100ps
module lfc_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clock,
  input  wire         nrst,
  // data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### hw/lfc_timer.v
// down counter with load, busy level and expiry pulse
`timescale 1ns/100ps
module lfc_timer #(
  parameter W = 32
) (
  // clock and reset
  input  wire         clock,
  input  wire         nrst,
  // control
  input  wire         load,
  input  wire         stop,
  input  wire [W-1:0] count,
  // status
  output wire         busy,
  output reg          done
);
  reg [W-1:0] cnt;

  assign busy = (cnt != {W{1'b0}});

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt  <= {W{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        cnt <= {W{1'b0}};
      end else if (load) begin
        cnt <= count;
      end else if (busy) begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        if (cnt == {{(W-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ### hw/lfc_top.v
// flash driver mode sequencer, fault latch and avalon register slave
//
// Contract
// - pa sync high during flash drops current to torch level.
// - pa sync low before flash end restores the flash level.
// - flash timeout turns current off regardless of pa sync.
// - monitor enabled and input low: ramp halts, level held.
// - timeout is 100 ms times field plus one, eight choices.
// - timer only ends flash; torch and indicator run on.
// - timeout, lockout, thermal and short faults clear mode bits.
// - overvoltage and current limit leave the mode bits alone.
// - lockout shuts down, flags; stays off until flags read.
// - reading flags clears them and lets operation resume.
// - lockout enable bit at zero disables lockout.
// - over temperature turns off, flags and goes to standby.
// - restart after thermal needs flags read; still hot refaults.
// - overvoltage while flash or torch reports open led.
// - led node low while flash or torch flags a short.
// - led sampled 256 us, output 2.048 ms after turn on.
// - source off until output ready, then steps level by level.
// - flash current has sixteen levels in the current register.
// - flash starts by register write or trigger pin high.
`timescale 1ns/100ps
`include "lfc_consts.vh"
module lfc_top #(
  parameter TO_STEP_CYC = `LFC_TO_STEP_MS * 1000 * `LFC_CLK_MHZ,
  parameter LED_DG_CYC  = `LFC_LED_DG_US * `LFC_CLK_MHZ,
  parameter OUT_DG_CYC  = `LFC_OUT_DG_US * `LFC_CLK_MHZ,
  parameter STEP_CYC    = `LFC_STEP_US * `LFC_CLK_MHZ
) (
  // clock and reset
  input  wire        clock,
  input  wire        nrst,
  // avalon-mm slave
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // hardware pins
  input  wire        flash_trigger_input,
  input  wire        pa_sync_input,
  // analog comparators
  input  wire        input_voltage_flash_monitor_below,
  input  wire        undervoltage_lockout_trip,
  input  wire        tsd_hot,
  input  wire        ovp_trip,
  input  wire        led_low,
  input  wire        vout_ready,
  input  wire        ilim_hit,
  // converter control
  output reg         led_on,
  output reg  [3:0]  led_level,
  output reg         led_torch_sel,
  output reg         boost_en
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_PRECH = 2'h1;
  localparam ST_RAMP  = 2'h2;
  localparam ST_RUN   = 2'h3;

  // ********************************************
  // pin and comparator synchronisers
  // ********************************************
  wire [8:0] sy;
  lfc_sync #(
    .W (9)
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .d     ({flash_trigger_input, pa_sync_input, input_voltage_flash_monitor_below, undervoltage_lockout_trip,
             tsd_hot, ovp_trip, led_low, vout_ready, ilim_hit}),
    .q     (sy)
  );
  wire s_trig  = sy[8];
  wire s_pa    = sy[7];
  wire s_input_voltage_flash_monitor  = sy[6];
  wire s_undervoltage_lockout  = sy[5];
  wire s_tsd   = sy[4];
  wire s_ovp   = sy[3];
  wire s_short = sy[2];
  wire s_vrdy  = sy[1];
  wire s_ilim  = sy[0];

  // ********************************************
  // registers
  // ********************************************
  reg  [7:0] en_reg;
  reg  [7:0] feat_reg;
  reg  [7:0] curr_reg;
  reg  [7:0] input_voltage_flash_monitor_reg;
  reg  [7:0] ramp_reg;
  reg  [5:0] flags;
  reg  [1:0] state;
  reg  [1:0] run_mode;
  reg  [3:0] level;
  reg        trig_d;
  reg        ilim_seen;
  reg        busy_cyc;

  function [3:0] reg_index;
    input [5:0] a;
    begin
      reg_index = a[5:2];
    end
  endfunction

  wire [3:0] idx    = reg_index(address);
  wire       acc    = (read | write) & ~busy_cyc;
  wire       wr_go  = write & busy_cyc;
  wire       rd_go  = read & busy_cyc;
  wire       wr_en  = wr_go & byteenable[0] & (idx == `LFC_IDX_ENABLE);
  wire       rd_flg = rd_go & (idx == `LFC_IDX_FLAGS);

  // ********************************************
  // mode request and fault inhibit
  // ********************************************
  wire [1:0] reg_mode = en_reg[`LFC_MODE_HI:`LFC_MODE_LO];
  wire trig_rise = s_trig & ~trig_d & en_reg[`LFC_EN_STROBE];
  wire undervoltage_lockout_on   = input_voltage_flash_monitor_reg[`LFC_INPUT_VOLTAGE_FLASH_MONITOR_LOW_INPUT_LOCK_ENABLE];
  // flags latch the inhibit; only a flags read lets it go
  wire inhibit   = flags[`LFC_FL_UNDERVOLTAGE_LOCKOUT] | flags[`LFC_FL_TSD]
                 | flags[`LFC_FL_SHORT];
  wire want_flash = (reg_mode == `LFC_MODE_FLASH) | trig_rise;
  wire [1:0] want = want_flash ? `LFC_MODE_FLASH : reg_mode;

  wire active = (state != ST_IDLE);
  wire lit_ft = active & ((run_mode == `LFC_MODE_FLASH)
                          | (run_mode == `LFC_MODE_TORCH));

  // ********************************************
  // timers: flash timeout, fault deglitch, ramp step
  // ********************************************
  wire        to_done;
  wire        to_busy;
  wire        led_dg_busy;
  wire        out_dg_busy;
  wire        step_busy;
  wire        start_lit = (state == ST_PRECH) & s_vrdy;
  wire [31:0] to_cnt = TO_STEP_CYC * ({29'h0,
                       feat_reg[`LFC_FEAT_TO_HI:`LFC_FEAT_TO_LO]} + 32'h1);

  lfc_timer #(.W (32)) u_to (
    .clock (clock),
    .nrst  (nrst),
    .load  (start_lit & (run_mode == `LFC_MODE_FLASH)),
    .stop  (~active),
    .count (to_cnt),
    .busy  (to_busy),
    .done  (to_done)
  );
  lfc_timer #(.W (32)) u_led_dg (
    .clock (clock),
    .nrst  (nrst),
    .load  (start_lit),
    .stop  (~active),
    .count (LED_DG_CYC),
    .busy  (led_dg_busy),
    .done  ()
  );
  lfc_timer #(.W (32)) u_out_dg (
    .clock (clock),
    .nrst  (nrst),
    .load  (start_lit),
    .stop  (~active),
    .count (OUT_DG_CYC),
    .busy  (out_dg_busy),
    .done  ()
  );
  lfc_timer #(.W (32)) u_step (
    .clock (clock),
    .nrst  (nrst),
    .load  (state == ST_RAMP & ~step_busy),
    .stop  (state != ST_RAMP),
    .count (STEP_CYC),
    .busy  (step_busy),
    .done  ()
  );

  // ********************************************
  // fault events
  // ********************************************
  wire sampled_led = lit_ft & (state != ST_PRECH) & ~led_dg_busy;
  wire sampled_out = lit_ft & (state != ST_PRECH) & ~out_dg_busy;
  wire ev_short = sampled_led & s_short;
  wire ev_ovp   = sampled_out & s_ovp;
  wire ev_undervoltage_lockout  = undervoltage_lockout_on & s_undervoltage_lockout;
  wire ev_tsd   = s_tsd & (active | reg_mode != `LFC_MODE_STBY);
  wire ev_to    = to_done;
  wire ev_input_voltage_flash_monitor  = en_reg[`LFC_EN_INPUT_VOLTAGE_FLASH_MONITOR] & s_input_voltage_flash_monitor
                & (run_mode == `LFC_MODE_FLASH) & active;
  // clearing faults; overvoltage and current limit are not among them
  wire kill = ev_to | ev_undervoltage_lockout | ev_tsd | ev_short;

  // target level: torch field or flash field
  wire [3:0] flash_lvl = curr_reg[`LFC_CURR_FL_HI:`LFC_CURR_FL_LO];
  wire [3:0] torch_lvl = {1'b0, curr_reg[`LFC_CURR_TO_HI:`LFC_CURR_TO_LO]};
  wire [3:0] target = (run_mode == `LFC_MODE_FLASH) ? flash_lvl : torch_lvl;
  wire pa_cut = en_reg[`LFC_EN_TX] & s_pa
              & (run_mode == `LFC_MODE_FLASH);

  // ********************************************
  // sequencer
  // ********************************************
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state    <= ST_IDLE;
      run_mode <= `LFC_MODE_STBY;
      level    <= 4'h0;
      trig_d   <= 1'b0;
    end else begin
      trig_d <= s_trig;
      case (state)
        ST_IDLE: begin
          level <= 4'h0;
          if (want != `LFC_MODE_STBY & ~inhibit & ~kill) begin
            run_mode <= want;
            state    <= ST_PRECH;
          end
        end
        ST_PRECH: begin
          if (s_vrdy) begin
            state <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (level >= target) begin
            state <= ST_RUN;
          end else if (ev_input_voltage_flash_monitor) begin
            state <= ST_RUN;
          end else if (~step_busy) begin
            level <= level + 4'h1;
          end
        end
        ST_RUN: begin
          if (level > target) begin
            level <= target;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // trigger-started flash is not held by the mode bits
      if (active & ~to_busy & run_mode == `LFC_MODE_FLASH
          & state == ST_RUN & reg_mode != `LFC_MODE_FLASH) begin
        state <= ST_IDLE;
      end
      if (active & (reg_mode == `LFC_MODE_STBY) & ~to_busy
          & run_mode != `LFC_MODE_FLASH) begin
        state <= ST_IDLE;
      end
      // a host write of standby ends flash or torch at once
      if (wr_en
          & (writedata[`LFC_MODE_HI:`LFC_MODE_LO] == `LFC_MODE_STBY)) begin
        state <= ST_IDLE;
      end
      if (kill) begin
        state <= ST_IDLE;
      end
    end
  end

  // ********************************************
  // register writes and flag latch
  // ********************************************
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_reg    <= `LFC_RST_ENABLE;
      feat_reg  <= `LFC_RST_FEAT;
      curr_reg  <= `LFC_RST_CURR;
      input_voltage_flash_monitor_reg  <= `LFC_RST_INPUT_VOLTAGE_FLASH_MONITOR;
      ramp_reg  <= 8'h00;
      flags     <= 6'h00;
      ilim_seen <= 1'b0;
    end else begin
      if (wr_go & byteenable[0]) begin
        case (idx)
          `LFC_IDX_ENABLE: en_reg   <= writedata[7:0];
          `LFC_IDX_FEAT:   feat_reg <= writedata[7:0];
          `LFC_IDX_CURR:   curr_reg <= writedata[7:0];
          `LFC_IDX_INPUT_VOLTAGE_FLASH_MONITOR:   input_voltage_flash_monitor_reg <= writedata[7:0];
          `LFC_IDX_RAMP:   ramp_reg <= writedata[7:0];
          default: ;
        endcase
      end
      if (kill & ~wr_en) begin
        en_reg[`LFC_MODE_HI:`LFC_MODE_LO] <= `LFC_MODE_STBY;
      end
      // set wins; a read clears only the bits it returned, so an
      // event landing between capture and clear is not lost
      flags <= (flags & ~(rd_flg ? readdata[5:0] : 6'h00))
             | {ev_input_voltage_flash_monitor, ev_undervoltage_lockout, ev_ovp, ev_short, ev_tsd, ev_to};
      ilim_seen <= s_ilim;
    end
  end

  // ********************************************
  // avalon slave: one wait cycle on every access
  // ********************************************
  reg [7:0] rd_mux;
  always @* begin
    case (idx)
      `LFC_IDX_ENABLE:  rd_mux = en_reg;
      `LFC_IDX_FLAGS:   rd_mux = {2'h0, flags};
      `LFC_IDX_FEAT:    rd_mux = feat_reg;
      `LFC_IDX_CURR:    rd_mux = curr_reg;
      `LFC_IDX_INPUT_VOLTAGE_FLASH_MONITOR:    rd_mux = input_voltage_flash_monitor_reg;
      `LFC_IDX_RAMP:    rd_mux = ramp_reg;
      `LFC_IDX_STATUS:  rd_mux = {ilim_seen, led_on, level, state};
      default:          rd_mux = 8'h00;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_cyc    <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      busy_cyc    <= acc;
      waitrequest <= ~acc;
      if (acc & read) begin
        readdata <= {24'h0, rd_mux};
      end
    end
  end

  // ********************************************
  // converter outputs
  // ********************************************
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      led_on        <= 1'b0;
      led_level     <= 4'h0;
      led_torch_sel <= 1'b0;
      boost_en      <= 1'b0;
    end else begin
      boost_en      <= active & ~kill;
      led_on        <= (state == ST_RAMP | state == ST_RUN) & ~kill;
      led_torch_sel <= pa_cut | (run_mode != `LFC_MODE_FLASH);
      led_level     <= pa_cut ? torch_lvl : level;
    end
  end
endmodule

// ### verification/lfc_analog.sv
// behavioural analog front end seen by the flash controller
`timescale 1ns/100ps
module lfc_analog #(
  parameter CHARGE_CYC = 4
) (
  // clock and reset
  input  wire clock,
  input  wire nrst,
  // converter side
  input  wire boost_en,
  input  wire short_cmd,
  // comparators
  output reg  vout_ready,
  output wire led_low
);
  reg [7:0] charge;
  // output cap only charges while the converter runs
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      charge <= 8'h00;
      vout_ready <= 1'b0;
    end else if (!boost_en) begin
      charge <= 8'h00;
      vout_ready <= 1'b0;
    end else if (charge < CHARGE_CYC) begin
      charge <= charge + 8'h01;
    end else begin
      vout_ready <= 1'b1;
    end
  end
  // led node collapses only when the bench shorts it
  assign led_low = short_cmd;
endmodule

// ### verification/lfc_top_chk.sv
// port assertions for the flash controller
`timescale 1ns/100ps
module lfc_top_chk #(
  parameter LED_DG_CYC = 10
) (
  input wire        clock,
  input wire        nrst,
  input wire        read,
  input wire        write,
  input wire        waitrequest,
  input wire        tsd_hot,
  input wire        led_low,
  input wire        vout_ready,
  input wire        led_on,
  input wire [3:0]  led_level,
  input wire        led_torch_sel,
  input wire        boost_en
);
  reg [15:0] low_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // cycles the led node has stayed low while lit
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      low_cnt <= 16'h0;
    else if (led_on && led_low)
      low_cnt <= low_cnt + 16'h1;
    else
      low_cnt <= 16'h0;
  end
  sequence s_req;
    $rose(read) || $rose(write);
  endsequence
  sequence s_ans;
    ##[1:3] !waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |-> s_ans)
    else $error("bus request not answered");
  a_wait_pulse: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!read && !write && !$past(read)
    && !$past(write) |-> waitrequest) else $error("idle slave answered");
  a_hot_dark: assert property ($rose(tsd_hot) |-> ##[1:6] !led_on)
    else $error("led still lit when hot");
  a_lit_ready: assert property ($rose(led_on) |-> $past(vout_ready, 2))
    else $error("led lit before output ready");
  a_lit_boost: assert property (led_on |-> boost_en)
    else $error("led lit with converter off");
  a_ramp_step: assert property (led_on && $past(led_on) && !led_torch_sel
    && !$past(led_torch_sel) && led_level > $past(led_level)
    |-> led_level == $past(led_level) + 4'h1) else $error("level skipped");
  a_short_dark: assert property (low_cnt == LED_DG_CYC + 8 |-> !led_on)
    else $error("short not acted on");
endmodule
bind lfc_top lfc_top_chk #(.LED_DG_CYC(LED_DG_CYC)) u_chk (.clock(clock),
  .nrst(nrst), .read(read), .write(write), .waitrequest(waitrequest),
  .tsd_hot(tsd_hot), .led_low(led_low), .vout_ready(vout_ready),
  .led_on(led_on), .led_level(led_level), .led_torch_sel(led_torch_sel),
  .boost_en(boost_en));

// ### verification/led_flash_mode_fault_control_bench.sv
// self-checking bench for the flash controller
`timescale 1ns/100ps
module led_flash_mode_fault_control_bench;
  reg         clock;
  reg         nrst;
  reg  [5:0]  address;
  reg         read;
  reg         write;
  reg  [31:0] writedata;
  wire [31:0] readdata;
  wire        waitrequest;
  reg         trig;
  reg         pa;
  reg         hot;
  reg         short_cmd;
  reg         undervoltage_lockout;
  reg         overvoltage_protection;
  reg         input_voltage_flash_monitor;
  reg         ilim;
  wire        vout_ready;
  wire        led_low;
  wire        led_on;
  wire [3:0]  led_level;
  wire        led_torch_sel;
  wire        boost_en;
  reg  [31:0] rd;
  integer     bad_count;
  integer     n_checks;
  integer     cyc = 0;
  // short counts keep the run small
  lfc_top #(.TO_STEP_CYC(50), .LED_DG_CYC(10), .OUT_DG_CYC(20),
    .STEP_CYC(2)) i_dut (.clock(clock), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest),
    .flash_trigger_input(trig), .pa_sync_input(pa), .input_voltage_flash_monitor_below(input_voltage_flash_monitor),
    .undervoltage_lockout_trip(undervoltage_lockout), .tsd_hot(hot), .ovp_trip(overvoltage_protection), .led_low(led_low),
    .vout_ready(vout_ready), .ilim_hit(ilim), .led_on(led_on),
    .led_level(led_level), .led_torch_sel(led_torch_sel),
    .boost_en(boost_en));
  lfc_analog i_ana (.clock(clock), .nrst(nrst), .boost_en(boost_en),
    .short_cmd(short_cmd), .vout_ready(vout_ready), .led_low(led_low));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [8*10:1] name, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  // one avalon access; idle edge after so strobes never toggle twice
  task bus(input w, input [3:0] idx, input [7:0] d);
    begin
      address <= {idx, 2'b00};
      writedata <= {24'h0, d};
      write <= w;
      read <= !w;
      @(posedge clock);
      while (waitrequest !== 1'b0)
        @(posedge clock);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
    end
  endtask
  task wait_led(input v, input integer lim);
    integer n;
    begin
      n = 0;
      while (led_on !== v && n < lim) begin
        @(posedge clock);
        n = n + 1;
      end
      chk("led_on", {31'h0, v}, {31'h0, led_on});
    end
  endtask
  task t_regs;
    begin
      bus(0, 4'h8, 0); chk("feat", 32'h52, rd);
      bus(0, 4'h9, 0); chk("curr", 32'h0F, rd);
      bus(0, 4'h1, 0); chk("input_voltage_flash_monitor", 32'h80, rd);
      bus(0, 4'hA, 0); chk("enable", 32'h00, rd);
      bus(1, 4'hF, 8'hFF);
      bus(0, 4'hF, 0); chk("unmapped", 32'h00, rd);
    end
  endtask
  task t_flash;
    integer t0;
    begin
      bus(1, 4'h8, 8'h51);
      bus(1, 4'hA, 8'h43);
      t0 = cyc;
      wait_led(1, 40);
      while (led_level !== 4'hF && cyc - t0 < 80)
        @(posedge clock);
      chk("flash_lvl", 32'h0F, {28'h0, led_level});
      pa <= 1'b1;
      repeat (6) @(posedge clock);
      chk("pa_torch", 32'h1, {31'h0, led_torch_sel});
      pa <= 1'b0;
      repeat (6) @(posedge clock);
      chk("pa_back", 32'h0F, {led_torch_sel, led_level});
      pa <= 1'b1;
      wait_led(0, 200);
      chk("to_len", 32'h1, {31'h0, cyc - t0 >= 98 && cyc - t0 <= 115});
      pa <= 1'b0;
      bus(0, 4'hA, 0); chk("mode_to", 32'h0, {30'h0, rd[1:0]});
      bus(0, 4'hB, 0); chk("flags_to", 32'h01, rd);
      bus(0, 4'hB, 0); chk("flags_clr", 32'h00, rd);
    end
  endtask
  task t_torch;
    begin
      bus(1, 4'hA, 8'h02);
      wait_led(1, 40);
      repeat (300) @(posedge clock);
      chk("torch_on", 32'h1, {31'h0, led_on});
      short_cmd <= 1'b1;
      wait_led(0, 60);
      short_cmd <= 1'b0;
      bus(0, 4'hB, 0); chk("flags_sh", 32'h04, rd);
      bus(0, 4'hA, 0); chk("mode_sh", 32'h0, {30'h0, rd[1:0]});
    end
  endtask
  task t_hot;
    begin
      bus(1, 4'hA, 8'h02);
      wait_led(1, 40);
      hot <= 1'b1;
      wait_led(0, 10);
      bus(0, 4'hA, 0); chk("mode_tsd", 32'h0, {30'h0, rd[1:0]});
      bus(0, 4'hB, 0); chk("flags_tsd", 32'h02, rd);
      bus(1, 4'hA, 8'h02);
      repeat (10) @(posedge clock);
      chk("led_hot", 32'h0, {31'h0, led_on});
      bus(0, 4'hB, 0); chk("flags_re", 32'h02, rd);
      hot <= 1'b0;
      bus(1, 4'hA, 8'h02);
      wait_led(1, 40);
      bus(1, 4'hA, 8'h00);
      wait_led(0, 80);
    end
  endtask
  task t_trig;
    begin
      bus(1, 4'hA, 8'h20);
      trig <= 1'b1;
      wait_led(1, 40);
      trig <= 1'b0;
      wait_led(0, 200);
      bus(0, 4'hB, 0); chk("flags_trg", 32'h01, rd);
    end
  endtask
  task t_cmd_end;
    begin
      bus(1, 4'hA, 8'h03);
      wait_led(1, 40);
      repeat (20) @(posedge clock);
      bus(1, 4'hA, 8'h00);
      wait_led(0, 10);
      bus(0, 4'hB, 0); chk("flags_cmd", 32'h00, rd);
    end
  endtask
  task t_input_voltage_flash_monitor;
    reg [3:0] held;
    begin
      bus(1, 4'hA, 8'h83);
      while (led_level !== 4'h4)
        @(posedge clock);
      input_voltage_flash_monitor <= 1'b1;
      repeat (12) @(posedge clock);
      held = led_level;
      repeat (30) @(posedge clock);
      chk("input_voltage_flash_monitor_hold", {28'h0, held}, {28'h0, led_level});
      chk("input_voltage_flash_monitor_low", 32'h1, {31'h0, led_level < 4'h8});
      input_voltage_flash_monitor <= 1'b0;
      wait_led(0, 200);
      bus(0, 4'hB, 0); chk("flags_iv", 32'h21, rd);
    end
  endtask
  task t_undervoltage_lockout;
    begin
      bus(1, 4'hA, 8'h02);
      wait_led(1, 40);
      undervoltage_lockout <= 1'b1;
      wait_led(0, 10);
      bus(0, 4'hA, 0); chk("mode_uv", 32'h0, {30'h0, rd[1:0]});
      undervoltage_lockout <= 1'b0;
      repeat (4) @(posedge clock);
      bus(1, 4'hA, 8'h02);
      repeat (10) @(posedge clock);
      chk("uv_held", 32'h0, {31'h0, led_on});
      bus(0, 4'hB, 0); chk("flags_uv", 32'h10, rd);
      wait_led(1, 40);
      bus(1, 4'h1, 8'h00);
      undervoltage_lockout <= 1'b1;
      repeat (10) @(posedge clock);
      chk("uv_off", 32'h1, {31'h0, led_on});
      undervoltage_lockout <= 1'b0;
      repeat (4) @(posedge clock);
      bus(1, 4'h1, 8'h80);
      bus(0, 4'hB, 0); chk("flags_uv0", 32'h00, rd);
      bus(1, 4'hA, 8'h00);
      wait_led(0, 80);
    end
  endtask
  task t_ovp;
    begin
      bus(1, 4'hA, 8'h02);
      wait_led(1, 40);
      repeat (30) @(posedge clock);
      {overvoltage_protection, ilim} <= 2'b11;
      repeat (6) @(posedge clock);
      bus(0, 4'hD, 0); chk("status", 32'hC3, rd);
      {overvoltage_protection, ilim} <= 2'b00;
      repeat (4) @(posedge clock);
      chk("ovp_lit", 32'h1, {31'h0, led_on});
      bus(0, 4'hA, 0); chk("mode_ovp", 32'h2, {30'h0, rd[1:0]});
      bus(0, 4'hB, 0); chk("flags_ovp", 32'h08, rd);
      bus(1, 4'hA, 8'h00);
      wait_led(0, 80);
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
    cyc <= cyc + 1;
  initial begin
    {nrst, read, write, trig, pa, hot, short_cmd, undervoltage_lockout, overvoltage_protection, input_voltage_flash_monitor, ilim}
      = 11'h000;
    address = 6'h00;
    writedata = 32'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_regs;
    t_flash;
    t_torch;
    t_hot;
    t_trig;
    t_cmd_end;
    t_input_voltage_flash_monitor;
    t_undervoltage_lockout;
    t_ovp;
    test_done;
  end
  // tests need around a thousand cycles; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge clock);
    bad_count = bad_count + 1;
    test_done;
  end
endmodule
